/* core/ssp_core.sv */
// Serial peripheral port: APB registers, master and slave shifter.
`timescale 1ns/100ps
module ssp_core (
    // System.
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Alternate master clock sources.
    input  wire logic                  sub_clk,
    input  wire logic                  tmr_match,
    // Link inputs.
    input  wire logic                  sck_i,
    input  wire logic                  sdi_i,
    input  wire logic                  scs_n_i,
    // Link outputs.
    output ssp_pkg::ssp_pins_out_t     pins,
    output logic                       transfer_done
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl2_q;
    logic [7:0] data_q;
    logic [7:0] pin_q;
    logic [3:0] cnt_q;
    logic [5:0] div_q;
    logic       sck_q;
    logic       sdo_q;
    logic       cap_dly_q;
    logic       cs_hold_q;
    logic       sub_q;
    logic       tmr_q;
    logic       lsck_q;
    logic       lscs_q;
    ssp_pkg::ssp_state_t state_q;
    logic [4:0] sync_q;

    ssp_sync #(.W(5)) u_sync (
        .mclk (mclk),
        .srst (srst),
        .d    ({sck_i, sdi_i, scs_n_i, sub_clk, tmr_match}),
        .q    (sync_q)
    );

    logic s_sck, s_sdi, s_scs_n, s_sub, s_tmr;
    assign {s_sck, s_sdi, s_scs_n, s_sub, s_tmr} = sync_q;

    logic [2:0] mode;
    logic       enable, spi_sel, is_master, is_slave;
    logic       idle_lvl, edge_sel, msb_first, cs_en;
    assign mode      = ctrl0_q[ssp_pkg::C0_MODE_LSB +: 3];
    assign enable    = ctrl0_q[ssp_pkg::C0_EN];
    // SPI only when the type bit is clear and the mode is not I2C/unused.
    assign spi_sel   = !ctrl0_q[ssp_pkg::C0_TYPE] && mode <= ssp_pkg::MODE_SLAVE;
    assign is_master = spi_sel && mode < ssp_pkg::MODE_SLAVE;
    assign is_slave  = spi_sel && mode == ssp_pkg::MODE_SLAVE;
    assign idle_lvl  = !ctrl2_q[ssp_pkg::C2_IDLE];
    assign edge_sel  = ctrl2_q[ssp_pkg::C2_EDGE];
    assign msb_first = ctrl2_q[ssp_pkg::C2_ORDER];
    assign cs_en     = ctrl2_q[ssp_pkg::C2_SELECT_PIN_ENABLE];

    ////////////////////////////////////////////////////////////////////////
    // APB decode; single-cycle answer.
    logic acc, wr, rd_ok, busy;
    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign pready  = 1'b1;
    assign busy    = state_q != ssp_pkg::ST_IDLE;

    always_comb begin
        rd_ok  = 1'b1;
        prdata = 32'h0000_0000;
        if (paddr == ssp_pkg::ADDR_CTRL0) begin
            prdata[7:0] = ctrl0_q;
        end else if (paddr == ssp_pkg::ADDR_CTRL2) begin
            prdata[7:0] = spi_sel ? ctrl2_q : 8'h00;
        end else if (paddr == ssp_pkg::ADDR_DATA) begin
            prdata[7:0] = spi_sel ? data_q : 8'h00;
        end else if (paddr == ssp_pkg::ADDR_PIN) begin
            prdata[7:0] = pin_q;
        end else begin
            rd_ok = 1'b0;
        end
    end
    assign pslverr = acc && !rd_ok;

    logic wr_c0, wr_c2, wr_d, wr_p;
    assign wr_c0 = wr && paddr == ssp_pkg::ADDR_CTRL0;
    assign wr_c2 = wr && paddr == ssp_pkg::ADDR_CTRL2 && spi_sel;
    assign wr_d  = wr && paddr == ssp_pkg::ADDR_DATA && spi_sel;
    assign wr_p  = wr && paddr == ssp_pkg::ADDR_PIN;

    ////////////////////////////////////////////////////////////////////////
    // Edge events for master and slave.
    logic m_tick, sck_rise, sck_fall, s_lead, s_trail, src_edge;
    logic [5:0] half;
    always_comb begin
        case (mode)
            ssp_pkg::MODE_DIV4:  half = ssp_pkg::HALF_DIV4;
            ssp_pkg::MODE_DIV16: half = ssp_pkg::HALF_DIV16;
            default:             half = ssp_pkg::HALF_DIV64;
        endcase
    end
    assign src_edge = (mode == ssp_pkg::MODE_SUB) ? (s_sub != sub_q) :
                      (s_tmr && !tmr_q);
    assign m_tick = (mode <= ssp_pkg::MODE_DIV64) ? (div_q == half) : src_edge;
    assign sck_rise = s_sck && !lsck_q;
    assign sck_fall = !s_sck && lsck_q;
    // Leading edge leaves idle level; trailing returns to it.
    assign s_lead  = idle_lvl ? sck_fall : sck_rise;
    assign s_trail = idle_lvl ? sck_rise : sck_fall;

    // Edge select set captures on the leading edge at either idle level.
    logic cap_lead;
    assign cap_lead = edge_sel;

    always_ff @(posedge mclk) begin
        if (srst) begin
            sub_q  <= 1'b0;
            tmr_q  <= 1'b0;
            lsck_q <= 1'b0;
            lscs_q <= 1'b1;
        end else begin
            sub_q  <= s_sub;
            tmr_q  <= s_tmr;
            lsck_q <= s_sck;
            lscs_q <= s_scs_n;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || !is_master || state_q == ssp_pkg::ST_IDLE) begin
            div_q <= 6'h00;
        end else if (div_q == half) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shifter state machine.
    logic lead_ev, trail_ev, start, sel_act, abort;
    assign sel_act  = !cs_en || !s_scs_n;
    assign lead_ev  = is_master ? m_tick : (s_lead && sel_act);
    assign trail_ev = is_master ? m_tick : (s_trail && sel_act);
    // Master starts on data write; slave waits for the remote clock.
    assign start = enable && is_master && wr_d;
    assign abort = is_slave && cs_en && s_scs_n && !lscs_q && busy;

    logic in_bit, cap_now, shift_in, done_ev;
    assign in_bit = s_sdi;
    assign cap_now   = cap_lead ? lead_ev : trail_ev;
    assign done_ev = busy && state_q == ssp_pkg::ST_TRAIL && trail_ev &&
                     cnt_q == ssp_pkg::BITS_PER_XFER - 4'h1;

    always_ff @(posedge mclk) begin
        if (srst || !enable || !spi_sel || abort) begin
            state_q <= ssp_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            case (state_q)
                ssp_pkg::ST_IDLE: begin
                    if (start || (is_slave && s_lead && sel_act)) begin
                        state_q <= is_slave ? ssp_pkg::ST_TRAIL
                                            : ssp_pkg::ST_LEAD;
                        cnt_q   <= 4'h0;
                    end
                end
                ssp_pkg::ST_LEAD: begin
                    if (lead_ev) begin
                        state_q <= ssp_pkg::ST_TRAIL;
                    end
                end
                ssp_pkg::ST_TRAIL: begin
                    if (trail_ev) begin
                        if (done_ev) begin
                            state_q <= ssp_pkg::ST_IDLE;
                        end else begin
                            state_q <= ssp_pkg::ST_LEAD;
                            cnt_q   <= cnt_q + 4'h1;
                        end
                    end
                end
                default: state_q <= ssp_pkg::ST_IDLE;
            endcase
        end
    end

    // Data register: one byte shifts out while the reply shifts in.
    logic ev_cap;
    assign ev_cap = busy && cap_now &&
                    (state_q == ssp_pkg::ST_LEAD) == cap_lead ||
                    (is_slave && state_q == ssp_pkg::ST_IDLE && s_lead &&
                     sel_act && cap_lead && enable);
    // The master shifts one cycle after its capture edge, so the synchroniser
    // hands over the bit that stood before it; select stays low one cycle.
    assign shift_in = is_master ? cap_dly_q : ev_cap;
    always_ff @(posedge mclk) begin
        if (srst) begin
            cap_dly_q <= 1'b0;
            cs_hold_q <= 1'b0;
        end else begin
            cap_dly_q <= is_master && ev_cap;
            cs_hold_q <= busy;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            data_q <= ssp_pkg::DATA_RST;
        end else if (wr_d && !busy) begin
            data_q <= pwdata[7:0];
        end else if (shift_in && spi_sel && enable) begin
            // Shift in one bit per capture edge.
            if (msb_first) begin
                data_q <= {data_q[6:0], in_bit};
            end else begin
                data_q <= {in_bit, data_q[7:1]};
            end
        end
    end

    // Output bit register follows the bit at the head of the shifter.
    always_ff @(posedge mclk) begin
        if (srst) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= msb_first ? data_q[7] : data_q[0];
        end
    end

    // Master serial clock toggles at each tick while busy.
    always_ff @(posedge mclk) begin
        if (srst) begin
            sck_q <= 1'b1;
        end else if (!busy || !is_master) begin
            sck_q <= idle_lvl;
        end else if (m_tick && state_q != ssp_pkg::ST_IDLE) begin
            sck_q <= !sck_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers; hardware set wins over software clear.
    logic write_collision_flag_ev;
    assign write_collision_flag_ev = wr_d && busy;
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl0_q <= ssp_pkg::CTRL0_RST;
        end else begin
            if (wr_c0) begin
                ctrl0_q <= pwdata[7:0];
            end
            if (abort) begin
                ctrl0_q[ssp_pkg::C0_INCMP] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl2_q <= ssp_pkg::CTRL2_RST;
        end else begin
            if (wr_c2) begin
                ctrl2_q <= pwdata[7:0];
            end
            if (done_ev || abort) begin
                ctrl2_q[ssp_pkg::C2_DONE] <= 1'b1;
            end
            if (write_collision_flag_ev) begin
                ctrl2_q[ssp_pkg::C2_WRITE_COLLISION_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_q <= ssp_pkg::PIN_RST;
        end else if (wr_p) begin
            pin_q <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive.
    logic active;
    assign active = enable && spi_sel && pin_q[ssp_pkg::PIN_ROUTE];
    always_comb begin
        pins.sck_o    = sck_q;
        pins.sck_oe   = active && is_master;
        pins.sdo_o    = sdo_q;
        pins.sdo_oe   = active && (is_master || sel_act);
        pins.scs_n_o  = !(busy || cs_hold_q);
        pins.scs_n_oe = active && is_master && cs_en;
        pins.pullup_en = active && pin_q[ssp_pkg::PIN_PULLUP];
    end
    assign transfer_done = ctrl2_q[ssp_pkg::C2_DONE];

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_collide;
        wr_d && busy;
    endsequence

    chk_write_collision_flag_set: assert property (@(posedge mclk) disable iff (srst)
        s_collide |=> ctrl2_q[ssp_pkg::C2_WRITE_COLLISION_FLAG])
        else $error("collision flag not set");
    chk_write_collision_flag_keep: assert property (@(posedge mclk) disable iff (srst)
        s_collide |=> data_q == $past(data_q) || $past(shift_in))
        else $error("data overwritten in transfer");
    chk_done_set: assert property (@(posedge mclk) disable iff (srst)
        done_ev |=> ctrl2_q[ssp_pkg::C2_DONE] && state_q == ssp_pkg::ST_IDLE)
        else $error("done flag not set");
    chk_done_hold: assert property (@(posedge mclk) disable iff (srst)
        ctrl2_q[ssp_pkg::C2_DONE] && !wr_c2 |=> ctrl2_q[ssp_pkg::C2_DONE])
        else $error("done flag cleared by hardware");
    chk_sck_idle: assert property (@(posedge mclk) disable iff (srst)
        !busy |=> sck_q == $past(idle_lvl))
        else $error("idle clock level wrong");
    chk_slave_noclk: assert property (@(posedge mclk) disable iff (srst)
        is_slave && !busy && !s_lead |=> !busy)
        else $error("slave left idle on its own");
    chk_cs_float: assert property (@(posedge mclk) disable iff (srst)
        !cs_en |-> !pins.scs_n_oe)
        else $error("select driven while disabled");
    chk_bit_count: assert property (@(posedge mclk) disable iff (srst)
        busy |-> cnt_q < ssp_pkg::BITS_PER_XFER)
        else $error("bit count overflow");
    chk_hidden_regs: assert property (@(posedge mclk) disable iff (srst)
        acc && !spi_sel && paddr == ssp_pkg::ADDR_DATA |-> prdata == 32'h0)
        else $error("data visible outside spi");
endmodule

/* core/ssp_pkg.sv */
// Package of constants and types for the serial peripheral port.
package ssp_pkg;

    // Register byte addresses on APB.
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_DATA  = 8'h08;
    localparam logic [7:0] ADDR_PIN   = 8'h0c;

    // Reset values.
    localparam logic [7:0] CTRL0_RST = 8'he0;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [7:0] PIN_RST   = 8'h00;

    // Field positions in serial_control_0.
    localparam int C0_MODE_LSB = 5;
    localparam int C0_TYPE     = 4;
    localparam int C0_DEB_LSB  = 2;
    localparam int C0_EN       = 1;
    localparam int C0_INCMP    = 0;

    // Field positions in serial_control_2.
    localparam int C2_IDLE  = 5;
    localparam int C2_EDGE  = 4;
    localparam int C2_ORDER = 3;
    localparam int C2_SELECT_PIN_ENABLE  = 2;
    localparam int C2_WRITE_COLLISION_FLAG  = 1;
    localparam int C2_DONE  = 0;

    // Field positions in the pin control register.
    localparam int PIN_ROUTE  = 0;
    localparam int PIN_PULLUP = 1;

    // Operating mode field codes.
    localparam logic [2:0] MODE_DIV4  = 3'h0;
    localparam logic [2:0] MODE_DIV16 = 3'h1;
    localparam logic [2:0] MODE_DIV64 = 3'h2;
    localparam logic [2:0] MODE_SUB   = 3'h3;
    localparam logic [2:0] MODE_TMR   = 3'h4;
    localparam logic [2:0] MODE_SLAVE = 3'h5;
    localparam logic [2:0] MODE_I2C   = 3'h6;

    // Half periods of the master serial clock in system cycles, less one.
    localparam logic [5:0] HALF_DIV4  = 6'h01;
    localparam logic [5:0] HALF_DIV16 = 6'h07;
    localparam logic [5:0] HALF_DIV64 = 6'h1f;

    localparam logic [3:0] BITS_PER_XFER = 4'h8;

    // Link pins seen from the device.
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
        logic scs_n_o;
        logic scs_n_oe;
        logic pullup_en;
    } ssp_pins_out_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_LEAD = 3'h2,
        ST_TRAIL = 3'h4
    } ssp_state_t;

endpackage

/* core/ssp_sync.sv */
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/100ps
module ssp_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         srst,
    // Data.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* tb/ssp_peer_model.sv */
// Behavioural SPI peripheral that answers the port while it is master.
`timescale 1ns/100ps
module ssp_peer_model (
    // Link.
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output logic            miso,
    // Control and observation.
    input  wire logic       cap_rise,
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte,
    output int              caps
);
    logic [7:0] sh_q;

    initial begin
        miso = 1'b0;
        rx_byte = 8'h00;
        caps = 0;
        sh_q = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // The peripheral never clocks the link; it follows the master.
    always @(negedge cs_n) begin
        sh_q = tx_byte;
        miso = tx_byte[7];
        caps = 0;
    end

    // A released line shows the inverse of its last level.
    always @(posedge cs_n) begin
        miso = ~miso;
    end

    // Capture on the selected edge, present the next bit on the other one.
    always @(sck) begin
        if (!cs_n && sck === cap_rise) begin
            rx_byte = {rx_byte[6:0], mosi};
            caps = caps + 1;
        end else if (!cs_n && caps > 0) begin
            sh_q = {sh_q[6:0], 1'b0};
            miso = sh_q[7];
        end
    end
endmodule

/* tb/serial_peripheral_port_tb.sv */
// Self-checking testbench of the serial peripheral port.
`timescale 1ns/100ps
`define check_eq(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end
module serial_peripheral_port_tb;
    logic                   mclk;
    logic                   srst;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [7:0]             paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   sub_clk;
    logic                   tmr_match;
    logic                   miso;
    logic                   cap_rise;
    logic [7:0]             peer_tx;
    logic [7:0]             peer_rx;
    int                     peer_caps;
    ssp_pkg::ssp_pins_out_t pins;
    logic                   transfer_done;
    wire                    sck_w;
    wire                    cs_w;
    int                     num_errors;
    int                     total_checks;

    // Both link lines carry pull-ups while nobody drives them.
    assign sck_w = pins.sck_oe ? pins.sck_o : 1'b1;
    assign cs_w  = pins.scs_n_oe ? pins.scs_n_o : 1'b1;

    ssp_core dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sub_clk(sub_clk),
        .tmr_match(tmr_match), .sck_i(sck_w), .sdi_i(miso),
        .scs_n_i(cs_w), .pins(pins), .transfer_done(transfer_done));

    ssp_peer_model peer (.sck(sck_w), .cs_n(cs_w), .mosi(pins.sdo_o),
        .miso(miso), .cap_rise(cap_rise), .tx_byte(peer_tx),
        .rx_byte(peer_rx), .caps(peer_caps));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        sub_clk = 1'b0;
        forever #40 sub_clk = ~sub_clk;
    end

    // Timer match toggles every third cycle: one rising edge per six.
    initial begin
        tmr_match = 1'b0;
        forever begin
            repeat (3) @(posedge mclk);
            tmr_match <= ~tmr_match;
        end
    end

    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
    endfunction

    task automatic finish_test;
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, {24'h0, d}, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(a, 1'b0, 32'h0, d, e);
    endtask

    task automatic settle;
        repeat (2) @(negedge mclk);
    endtask

    // Routes the pins and programs both control registers.
    task automatic setup(input logic [2:0] mode, input logic en,
                         input logic [7:0] c2);
        wr(ssp_pkg::ADDR_PIN, 8'h03);
        wr(ssp_pkg::ADDR_CTRL0, {mode, 1'b0, 2'b00, en, 1'b0});
        wr(ssp_pkg::ADDR_CTRL2, c2);
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] v;
        logic        e;
        rd(ssp_pkg::ADDR_CTRL0, v);
        `check_eq(v[7:0], 8'he0)
        wr(ssp_pkg::ADDR_CTRL2, 8'h3c);
        rd(ssp_pkg::ADDR_CTRL2, v);
        `check_eq(v[7:0], 8'h00)
        apb(8'h10, 1'b0, 32'h0, v, e);
        `check_eq(e, 1'b1)
        wr(ssp_pkg::ADDR_CTRL0, 8'h12);
        wr(ssp_pkg::ADDR_CTRL2, 8'h0c);
        rd(ssp_pkg::ADDR_CTRL2, v);
        `check_eq(v[7:0], 8'h00)
    endtask

    task automatic t_pins;
        setup(ssp_pkg::MODE_DIV16, 1'b1, 8'h04);
        `check_eq(pins.scs_n_oe, 1'b1)
        `check_eq(pins.sck_oe, 1'b1)
        `check_eq(pins.sdo_oe, 1'b1)
        `check_eq(pins.pullup_en, 1'b1)
        setup(ssp_pkg::MODE_DIV16, 1'b1, 8'h00);
        `check_eq(pins.scs_n_oe, 1'b0)
        setup(ssp_pkg::MODE_DIV16, 1'b0, 8'h04);
        `check_eq(pins.sck_oe, 1'b0)
        `check_eq(pins.pullup_en, 1'b0)
    endtask

    // One master transfer; measures a half period of the serial clock.
    task automatic t_xfer(input logic [2:0] mode, input int div,
                          input logic [7:0] c2, input logic [7:0] tx,
                          input logic [7:0] ptx);
        logic [31:0] v;
        logic        prev;
        int          cnt;
        int          tog;
        int          meas;
        cnt = 0;
        tog = 0;
        meas = 0;
        peer_tx <= ptx;
        cap_rise <= ~(c2[5] ^ c2[4]);
        setup(mode, 1'b1, c2);
        `check_eq(sck_w, ~c2[5])
        wr(ssp_pkg::ADDR_DATA, tx);
        prev = pins.sck_o;
        while (transfer_done !== 1'b1) begin
            @(posedge mclk);
            cnt++;
            if (pins.sck_o !== prev) begin
                tog++;
                if (tog == 3) meas = cnt;
                cnt = 0;
                prev = pins.sck_o;
            end
        end
        `check_eq(meas, div / 2)
        `check_eq(peer_caps, 8)
        `check_eq(peer_rx, c2[3] ? tx : rev8(tx))
        rd(ssp_pkg::ADDR_DATA, v);
        `check_eq(v[7:0], c2[3] ? ptx : rev8(ptx))
        repeat (20) @(negedge mclk);
        rd(ssp_pkg::ADDR_CTRL2, v);
        `check_eq(v[7:0], c2 | 8'h01)
        wr(ssp_pkg::ADDR_CTRL2, c2);
        settle();
        `check_eq(transfer_done, 1'b0)
    endtask

    task automatic t_collision;
        logic [31:0] v;
        peer_tx <= 8'h00;
        cap_rise <= 1'b1;
        setup(ssp_pkg::MODE_DIV16, 1'b1, 8'h0c);
        wr(ssp_pkg::ADDR_DATA, 8'ha5);
        wr(ssp_pkg::ADDR_DATA, 8'h3c);
        while (transfer_done !== 1'b1) begin
            @(posedge mclk);
        end
        rd(ssp_pkg::ADDR_CTRL2, v);
        `check_eq(v[1:0], 2'b11)
        `check_eq(peer_rx, 8'ha5)
    endtask

    task automatic t_slave;
        setup(ssp_pkg::MODE_SLAVE, 1'b1, 8'h04);
        wr(ssp_pkg::ADDR_DATA, 8'h55);
        repeat (100) @(negedge mclk);
        `check_eq(pins.sck_oe, 1'b0)
        `check_eq(transfer_done, 1'b0)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        total_checks = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cap_rise = 1'b1;
        peer_tx = 8'h00;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_pins();
        t_xfer(ssp_pkg::MODE_DIV16, 16, 8'h0c, 8'h96, 8'h3a);
        t_xfer(ssp_pkg::MODE_DIV16, 16, 8'h14, 8'hc1, 8'h81);
        t_xfer(ssp_pkg::MODE_DIV4, 4, 8'h2c, 8'h5a, 8'hff);
        t_xfer(ssp_pkg::MODE_DIV64, 64, 8'h34, 8'h1e, 8'h6d);
        t_xfer(ssp_pkg::MODE_SUB, 8, 8'h0c, 8'he7, 8'h42);
        t_xfer(ssp_pkg::MODE_TMR, 12, 8'h24, 8'h3c, 8'hc3);
        t_collision();
        t_slave();
        finish_test();
    end

    initial begin
        repeat (50000) @(posedge mclk);
        num_errors++;
        finish_test();
    end
endmodule
